// file: core/rc_lockout.sv
// Purpose: Reclose sequencing, lockout latch, reset paths and trip indicator.
// Assumes: Breaker status, pole dead, reset and block inputs are asynchronous pins.
// Notes:   Comparators and analog measurement live outside; only their results enter.
`timescale 1ns/10ps
module rc_lockout
  import rc_pkg::*;
#(
  parameter int TICK_DIV = rc_pkg::MS_CYC
)
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  input  wire rc_pkg::rc_cfg_t      CFG,
  input  wire rc_pkg::rc_prot_t     PROT,
  input  wire rc_pkg::rc_cmd_t      CMD,
  input  wire logic [3:0]           PIN_IN,
  input  wire logic [7:0]           CB_FAULT,
  input  wire logic                 THREE_PH_LIVE,
  input  wire logic                 ONE_PH_LIVE,
  input  wire logic                 SYNC_IN_LIMITS,
  output logic                      LOCKOUT,
  output logic [4:0]                LOCKOUT_CAUSE,
  output rc_pkg::rc_seq_t           SEQ_STATE,
  output logic [2:0]                SHOT_COUNT,
  output logic                      RECLOSE_CMD,
  output logic                      CLOSE_PERMIT,
  output logic                      BLOCK_INST_MAIN,
  output logic                      BLOCK_INST_SEF,
  output logic                      TRIP_LED,
  output logic                      FLAGS_SHOWN,
  output logic                      FAULT_REC_CLR,
  output logic                      FLAGS_CLR,
  output logic                      BUS_LIVE,
  output logic                      LINE_LIVE,
  output rc_pkg::rc_phase_t         SYNC_REF
);
  import rc_pkg::*;

  rc_st_t           s_reg;
  rc_st_t           s_next;
  logic             tick;
  logic             cb;
  logic             cb_rise;
  logic             cb_fall;
  logic             blk;
  logic             starts;
  logic             start_rise;
  logic             prot_op;
  logic             seqc;
  logic             in_prog;
  logic [C_N-1:0]   c;
  logic             rst_ok;
  logic             mc_done;
  logic             na_entry;
  logic             clr;
  logic             trig;
  logic             can_init;
  logic             shot_ev;
  logic             first_skip;
  logic             chk_ok;
  logic [2:0]       idx;

  function automatic logic [TMR_W-1:0] step(input logic [TMR_W-1:0] v, input logic t);
    step = t ? v + 1'b1 : v;
  endfunction

  rc_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .core_clk (CORE_CLK),
    .rst_n    (RST_N),
    .tick     (tick)
  );

  assign cb = s_reg.pin[PIN_CB_CLOSED];
  assign cb_rise = cb & ~s_reg.cb_d;
  assign cb_fall = ~cb & s_reg.cb_d;
  assign blk = s_reg.pin[PIN_BLOCK];
  assign starts = PROT.main_start | PROT.sef_start;
  assign start_rise = starts & ~s_reg.start_d;
  assign prot_op = PROT.main_trip | PROT.sef_trip;
  assign seqc = CFG.sequence_coordination_enable;
  assign in_prog = s_reg.seq != RC_IDLE;

  // Live lockout causes; they are latched into the alarm bits below
  always_comb
  begin
    c = '0;
    c[C_INACT] = prot_op & (CFG.mode != RC_AUTO) & CFG.inactive_trip_response; // [RULE1]
    c[C_MCOF] = prot_op & s_reg.inhib & CFG.man_close_flt_lockout; // [RULE2]
    c[C_CB] = |CB_FAULT; // [RULE3]
    c[C_FINAL] = prot_op & (s_reg.seq == RC_RECLAIM) & (s_reg.shots >= CFG.shots_max); // [RULE19]
    c[C_BLOCK] = blk & in_prog; // [RULE20]
  end

  // The pin reset is refused while any cause is still present
  assign rst_ok = s_reg.pin[PIN_RST_LOCK] & ~|c; // [RULE4]
  assign mc_done = s_reg.mc & cb & (s_reg.mcnt >= CFG.mc_rst_ms); // [RULE6]
  assign na_entry = (CFG.mode == RC_NON_AUTO) & (s_reg.mode_d != RC_NON_AUTO)
                    & CFG.lockout_reset_source_non_auto; // [RULE7]
  assign clr = CMD.clear_key | CMD.cb_lockout_reset | rst_ok | mc_done | na_entry; // [RULE5]

  // Without coordination a shot needs the breaker to open after a trip
  assign trig = seqc ? start_rise : (cb_fall & s_reg.trip_pend); // [RULE8] [RULE10]
  assign can_init = (CFG.mode == RC_AUTO) & ~s_reg.lockout & ~blk & ~s_reg.inhib & ~|c; // [RULE21] [RULE20]
  assign shot_ev = trig & can_init & (s_reg.shots < CFG.shots_max)
                   & ((s_reg.seq == RC_IDLE) | (s_reg.seq == RC_RECLAIM));

  assign first_skip = (s_reg.shots == 3'h1) & ~CFG.sys_chk_shot1; // [RULE12]
  assign chk_ok = ~(s_reg.bus_live & s_reg.line_live) | SYNC_IN_LIMITS; // [RULE16]
  assign idx = (s_reg.shots < 3'(MAX_TRIPS)) ? s_reg.shots : 3'(MAX_TRIPS - 1);

  always_comb
  begin
    s_next = s_reg;
    s_next.s1 = PIN_IN;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    if (s_reg.s2 == s_reg.s3)
      s_next.pin = s_reg.s3;
    s_next.cb_d = cb;
    s_next.start_d = starts;
    s_next.mode_d = CFG.mode;
    s_next.trip_pend = prot_op | (s_reg.trip_pend & cb);
    s_next.rec_clr = 1'b0;
    s_next.flg_clr = 1'b0;

    // Location setting decides which input faces the bus
    if (CFG.primary_voltage_input_side)
    begin
      s_next.bus_live = ONE_PH_LIVE; // [RULE17]
      s_next.line_live = THREE_PH_LIVE;
    end
    else
    begin
      s_next.bus_live = THREE_PH_LIVE;
      s_next.line_live = ONE_PH_LIVE;
    end
    s_next.sync_ref = CFG.phase_sel; // [RULE18]
    s_next.permit = chk_ok;
    s_next.bim = CFG.blk_inst_main[idx]; // [RULE11]
    s_next.bis = CFG.blk_inst_sef[idx]; // [RULE11]

    // Manual close opens the inhibit window and the reset delay
    if (cb_rise & (s_reg.seq == RC_IDLE))
    begin
      if (CFG.man_close_inhibit)
      begin
        s_next.inhib = 1'b1;
        s_next.icnt = '0;
      end
      if (s_reg.lockout & CFG.lockout_reset_source_close)
      begin
        s_next.mc = 1'b1;
        s_next.mcnt = '0;
      end
    end
    else
    begin
      if (s_reg.inhib)
      begin
        s_next.icnt = step(s_reg.icnt, tick);
        if (s_reg.icnt >= CFG.inhibit_ms)
          s_next.inhib = 1'b0;
      end
      if (s_reg.mc)
      begin
        s_next.mcnt = step(s_reg.mcnt, tick);
        if (!cb || mc_done || !s_reg.lockout)
          s_next.mc = 1'b0;
      end
    end

    case (s_reg.seq)
      RC_IDLE:
      begin
        if (shot_ev)
        begin
          s_next.shots = s_reg.shots + 1'b1; // [RULE8] [RULE10]
          s_next.tmr = '0;
          s_next.seq = RC_DEAD;
        end
      end
      RC_DEAD:
      begin
        s_next.tmr = step(s_reg.tmr, tick);
        if (s_reg.tmr >= CFG.dead_ms)
          s_next.seq = RC_CLOSING;
      end
      RC_CLOSING:
      begin
        // Coordinated reclaim also waits for all starts to drop
        if (cb && !(seqc && starts)) // [RULE9]
        begin
          s_next.tmr = '0;
          s_next.seq = RC_RECLAIM;
        end
      end
      RC_RECLAIM:
      begin
        if (shot_ev)
        begin
          s_next.shots = s_reg.shots + 1'b1; // [RULE8] [RULE10]
          s_next.tmr = '0;
          s_next.seq = RC_DEAD;
        end
        else
        begin
          if (!(seqc && starts))
            s_next.tmr = step(s_reg.tmr, tick);
          if (s_reg.tmr >= CFG.reclaim_ms)
          begin
            s_next.shots = '0;
            s_next.seq = RC_IDLE;
          end
        end
      end
      default:
        s_next.seq = RC_IDLE;
    endcase

    // Set wins over clear so a fresh cause is never lost
    if (clr)
    begin
      s_next.lockout = 1'b0;
      s_next.cause = '0; // [RULE4]
    end
    if (|c)
    begin
      s_next.lockout = 1'b1; // [RULE21]
      s_next.cause = s_next.cause | c;
      s_next.seq = RC_IDLE;
      s_next.shots = '0;
    end

    // Trip indicator: auto reset armed by a close, killed by any start
    if (CFG.system_function_link_bit && cb_rise && s_reg.led)
    begin
      s_next.arm = 1'b1; // [RULE14]
      s_next.lcnt = '0;
    end
    else if (s_reg.arm)
    begin
      if (PROT.any_start)
        s_next.arm = 1'b0; // [RULE15]
      else if (s_reg.pin[PIN_POLE_DEAD])
        s_next.lcnt = '0;
      else if (s_reg.lcnt >= LED_AUTO_MS)
      begin
        s_next.arm = 1'b0; // [RULE14]
        s_next.led = 1'b0;
        s_next.shown = 1'b0;
      end
      else if (tick)
        s_next.lcnt = s_reg.lcnt + 1'b1;
    end
    if (CMD.flag_view)
      s_next.shown = 1'b1;
    if (CMD.led_reset && s_reg.shown)
    begin
      s_next.led = 1'b0; // [RULE13]
      s_next.shown = 1'b0;
      s_next.rec_clr = 1'b1;
    end
    if (CMD.clear_key)
    begin
      s_next.led = 1'b0; // [RULE5]
      s_next.shown = 1'b0;
      s_next.arm = 1'b0;
      s_next.flg_clr = 1'b1;
    end
    if (prot_op)
    begin
      s_next.led = 1'b1; // [RULE13]
      s_next.shown = 1'b1;
      s_next.arm = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign LOCKOUT = s_reg.lockout;
  assign LOCKOUT_CAUSE = s_reg.cause;
  assign SEQ_STATE = s_reg.seq;
  assign SHOT_COUNT = s_reg.shots;
  // Close request is a handshake: held until the breaker reports closed
  assign RECLOSE_CMD = (s_reg.seq == RC_CLOSING) & ~cb & (first_skip | s_reg.permit)
                       & ~s_reg.lockout & ~blk; // [RULE12] [RULE21]
  assign CLOSE_PERMIT = s_reg.permit;
  assign BLOCK_INST_MAIN = s_reg.bim;
  assign BLOCK_INST_SEF = s_reg.bis;
  assign TRIP_LED = s_reg.led;
  assign FLAGS_SHOWN = s_reg.shown;
  assign FAULT_REC_CLR = s_reg.rec_clr;
  assign FLAGS_CLR = s_reg.flg_clr;
  assign BUS_LIVE = s_reg.bus_live;
  assign LINE_LIVE = s_reg.line_live;
  assign SYNC_REF = s_reg.sync_ref;

  default clocking cb_clk @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  a_inactive_trip_lock: assert property ( // [RULE1]
    prot_op && CFG.mode != RC_AUTO && CFG.inactive_trip_response |=> LOCKOUT && LOCKOUT_CAUSE[C_INACT])
    else $error("trip with reclose inactive did not lock out");
  a_man_close_lock: assert property ( // [RULE2]
    prot_op && s_reg.inhib && CFG.man_close_flt_lockout |=> LOCKOUT)
    else $error("trip in inhibit window did not lock out");
  a_cb_fault_lock: assert property ( // [RULE3]
    |CB_FAULT |=> LOCKOUT && LOCKOUT_CAUSE[C_CB])
    else $error("breaker fault did not lock out");
  a_reset_gated: assert property ( // [RULE4]
    LOCKOUT && s_reg.pin[PIN_RST_LOCK] && c == '0 |=> !LOCKOUT && LOCKOUT_CAUSE == '0)
    else $error("reset input failed to clear lockout");
  a_key_clear: assert property ( // [RULE5]
    CMD.clear_key && c == '0 |=> !LOCKOUT && FLAGS_CLR ##1 (!FLAGS_CLR || $past(CMD.clear_key)))
    else $error("clear key failed");
  a_mc_reset: assert property ( // [RULE6]
    mc_done && c == '0 |=> !LOCKOUT)
    else $error("manual close reset delay did not clear lockout");
  a_non_auto_reset: assert property ( // [RULE7]
    LOCKOUT && $changed(CFG.mode) && CFG.mode == RC_NON_AUTO && !CFG.lockout_reset_source_non_auto
    && !CMD.clear_key && !CMD.cb_lockout_reset && !rst_ok && !mc_done |=> LOCKOUT)
    else $error("non-auto entry cleared lockout while not selected");
  a_seq_shot: assert property ( // [RULE8]
    seqc && shot_ev |=> SEQ_STATE == RC_DEAD && SHOT_COUNT == $past(SHOT_COUNT) + 3'h1)
    else $error("coordinated start did not advance shot");
  a_reclaim_wait: assert property ( // [RULE9]
    seqc && SEQ_STATE == RC_CLOSING && starts |=> SEQ_STATE != RC_RECLAIM)
    else $error("reclaim started while starts active");
  a_nonseq_count: assert property ( // [RULE10]
    !seqc && !cb_fall |=> SHOT_COUNT <= $past(SHOT_COUNT))
    else $error("shot counted without breaker trip");
  a_shot_check: assert property ( // [RULE12]
    RECLOSE_CMD && SHOT_COUNT != 3'h1 |-> CLOSE_PERMIT)
    else $error("later shot reclosed without system check");
  a_led_ack: assert property ( // [RULE13]
    CMD.led_reset && !FLAGS_SHOWN && !CMD.clear_key |=> !FAULT_REC_CLR)
    else $error("indicator reset accepted without flags shown");
  a_led_start_kill: assert property ( // [RULE15]
    PROT.any_start && !(CFG.system_function_link_bit && cb_rise && s_reg.led) |=> !s_reg.arm)
    else $error("auto reset stayed armed after start");
  a_vt_side: assert property ( // [RULE17]
    CFG.primary_voltage_input_side && $stable(CFG.primary_voltage_input_side) |=> BUS_LIVE == $past(ONE_PH_LIVE))
    else $error("bus side mapping wrong");
  a_no_reclose_locked: assert property ( // [RULE21]
    LOCKOUT |-> !RECLOSE_CMD ##1 SEQ_STATE != RC_DEAD || !$past(LOCKOUT))
    else $error("reclose activity while locked out");

  c_full_shot: cover property (SEQ_STATE == RC_DEAD ##[1:1000] SEQ_STATE == RC_RECLAIM);
  c_final_lock: cover property (c[C_FINAL] ##1 LOCKOUT);
  c_led_auto: cover property (s_reg.arm ##1 !TRIP_LED && !s_reg.arm);
endmodule

// file: core/rc_pkg.sv
// Purpose: Shared constants and types for the reclose lockout control block.
// Assumes: One 40 MHz core clock; settings and protection inputs are synchronous.
// Notes:   All timing runs from a 1 ms tick made by a clock divider.
// Operation
// [RULE1] Trip in non-auto or live-line mode locks out
// [RULE2] Trip during manual close inhibit locks out
// [RULE3] Breaker supervision faults force lockout
// [RULE4] Reset input clears only once causes gone
// [RULE5] Clear key and breaker command always clear; code keeps lockout set while a cause is still present
// [RULE6] Manual close plus delay clears when selected
// [RULE7] Entering non-auto clears lockout when selected
// [RULE8] Coordinated start counts shot, starts dead time
// [RULE9] Reclaim waits for dead end, starts low
// [RULE10] Uncoordinated: only breaker trip counts shots
// [RULE11] Per-trip instantaneous block for main, earth
// [RULE12] First shot may skip system check
// [RULE13] Trip shows flags; ack only while shown
// [RULE14] Auto indicator reset after three seconds closed
// [RULE15] Start after close cancels auto indicator reset
// [RULE16] Both sides live need synchronism check
// [RULE17] Location setting maps inputs to bus, line
// [RULE18] Check input phase chosen from six
// [RULE19] Trip in reclaim after last shot locks
// [RULE20] Block inhibits, locks out cycle in progress
// [RULE21] Lockout latched; no reclose while latched
package rc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 16;
  localparam int LED_AUTO_S = 3;
  localparam int LED_W = 12;
  localparam logic [LED_W-1:0] LED_AUTO_MS = LED_W'(LED_AUTO_S * 1000);
  localparam int SHOT_W = 3;
  localparam int MAX_TRIPS = 5;
  localparam int TMR_W = 16;
  localparam int NCB = 8;
  localparam int PIN_CB_CLOSED = 0;
  localparam int PIN_POLE_DEAD = 1;
  localparam int PIN_RST_LOCK = 2;
  localparam int PIN_BLOCK = 3;
  localparam int PIN_N = 4;
  localparam int C_INACT = 0;
  localparam int C_MCOF = 1;
  localparam int C_CB = 2;
  localparam int C_FINAL = 3;
  localparam int C_BLOCK = 4;
  localparam int C_N = 5;

  typedef enum logic [1:0] {RC_AUTO, RC_NON_AUTO, RC_LIVE_LINE} rc_mode_t;
  typedef enum logic [2:0] {RC_AN, RC_BN, RC_CN, RC_AB, RC_BC, RC_CA} rc_phase_t;
  typedef enum logic [1:0] {RC_IDLE, RC_DEAD, RC_CLOSING, RC_RECLAIM} rc_seq_t;

  typedef struct packed {
    rc_mode_t                mode;
    logic                    inactive_trip_response;
    logic                    man_close_flt_lockout;
    logic                    man_close_inhibit;
    logic                    sequence_coordination_enable;
    logic                    lockout_reset_source_close;
    logic                    lockout_reset_source_non_auto;
    logic                    sys_chk_shot1;
    logic                    system_function_link_bit;
    logic                    primary_voltage_input_side;
    rc_phase_t               phase_sel;
    logic [SHOT_W-1:0]       shots_max;
    logic [MAX_TRIPS-1:0]    blk_inst_main;
    logic [MAX_TRIPS-1:0]    blk_inst_sef;
    logic [TMR_W-1:0]        dead_ms;
    logic [TMR_W-1:0]        reclaim_ms;
    logic [TMR_W-1:0]        inhibit_ms;
    logic [TMR_W-1:0]        mc_rst_ms;
  } rc_cfg_t;

  typedef struct packed {
    logic main_start;
    logic sef_start;
    logic any_start;
    logic main_trip;
    logic sef_trip;
  } rc_prot_t;

  typedef struct packed {
    logic clear_key;
    logic cb_lockout_reset;
    logic led_reset;
    logic flag_view;
  } rc_cmd_t;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } rc_tick_st_t;

  typedef struct packed {
    logic [PIN_N-1:0]  s1;
    logic [PIN_N-1:0]  s2;
    logic [PIN_N-1:0]  s3;
    logic [PIN_N-1:0]  pin;
    logic              cb_d;
    logic              start_d;
    logic              trip_pend;
    rc_mode_t          mode_d;
    rc_seq_t           seq;
    logic [SHOT_W-1:0] shots;
    logic [TMR_W-1:0]  tmr;
    logic [TMR_W-1:0]  icnt;
    logic [TMR_W-1:0]  mcnt;
    logic [LED_W-1:0]  lcnt;
    logic              lockout;
    logic              inhib;
    logic              mc;
    logic              arm;
    logic              led;
    logic              shown;
    logic              rec_clr;
    logic              flg_clr;
    logic              bus_live;
    logic              line_live;
    logic              bim;
    logic              bis;
    logic              permit;
    logic [C_N-1:0]    cause;
    rc_phase_t         sync_ref;
  } rc_st_t;
endpackage

// file: core/rc_tick.sv
// Purpose: Divides the core clock into a one-cycle millisecond enable.
// Assumes: DIV is at least 2 and fits the counter width.
// Notes:   The tick comes from a flop, so it never glitches.
`timescale 1ns/10ps
module rc_tick
  import rc_pkg::*;
#(
  parameter int DIV = 40000
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  rc_tick_st_t t_reg;
  rc_tick_st_t t_next;

  always_comb
  begin
    t_next = t_reg;
    t_next.tick = 1'b0;
    if (t_reg.cnt == TICK_W'(DIV - 1))
    begin
      t_next.cnt = '0;
      t_next.tick = 1'b1;
    end
    else
      t_next.cnt = t_reg.cnt + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign tick = t_reg.tick;
endmodule

// file: tb/rc_breaker.sv
// Purpose: Behavioural breaker facing the reclose block.
// Assumes: Close request is a level held until the breaker has closed.
// Notes:   Closing takes CLOSE_CYC cycles; a trip request opens at once.
`timescale 1ns/10ps
module rc_breaker
#(
  parameter int CLOSE_CYC = 6
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic close_cmd,
  input  wire logic trip_cmd,
  output logic      closed,
  output logic      pole_dead
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      closed <= 1'b0;
      cnt    <= 0;
    end
    else if (trip_cmd)
    begin
      closed <= 1'b0;
      cnt    <= 0;
    end
    else if (close_cmd && !closed)
    begin
      cnt <= cnt + 1;
      if (cnt == CLOSE_CYC - 1)
        closed <= 1'b1;
    end
    else
      cnt <= 0;
  end
  // Any pole dead follows the open breaker
  assign pole_dead = !closed;
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the reclose lockout block.
// Assumes: Tick divider shortened to 4 cycles per millisecond.
// Notes:   Inputs change 2 ns after the rising edge.
`timescale 1ns/10ps
module tb_top;
  import rc_pkg::*;
  logic core_clk;
  logic rst_n;
  rc_cfg_t cfg;
  rc_prot_t prot;
  rc_cmd_t cmd;
  logic pin_rst, pin_blk, cb_trip, man_close, cb_closed, pole_dead;
  logic [7:0] cb_fault;
  logic three_live, one_live, sync_ok;
  logic lockout, reclose, permit, led, shown, rec_clr, flg_clr, bus_live, line_live;
  logic bim, bis;
  logic [4:0] cause;
  logic [2:0] shots;
  rc_seq_t seq;
  rc_phase_t sref;
  int n_errors;
  int num_checks;

  rc_lockout #(.TICK_DIV(4)) i_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CFG(cfg), .PROT(prot), .CMD(cmd),
    .PIN_IN({pin_blk, pin_rst, pole_dead, cb_closed}), .CB_FAULT(cb_fault),
    .THREE_PH_LIVE(three_live), .ONE_PH_LIVE(one_live), .SYNC_IN_LIMITS(sync_ok),
    .LOCKOUT(lockout), .LOCKOUT_CAUSE(cause), .SEQ_STATE(seq), .SHOT_COUNT(shots),
    .RECLOSE_CMD(reclose), .CLOSE_PERMIT(permit), .BLOCK_INST_MAIN(bim), .BLOCK_INST_SEF(bis),
    .TRIP_LED(led), .FLAGS_SHOWN(shown), .FAULT_REC_CLR(rec_clr), .FLAGS_CLR(flg_clr),
    .BUS_LIVE(bus_live), .LINE_LIVE(line_live), .SYNC_REF(sref));

  rc_breaker i_cb (.clk(core_clk), .rst_n(rst_n), .close_cmd(reclose | man_close),
                   .trip_cmd(cb_trip), .closed(cb_closed), .pole_dead(pole_dead));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_seq(input rc_seq_t s, input int bound);
    int i;
    i = 0;
    while (seq !== s && i < bound)
    begin
      cyc(1);
      i++;
    end
    if (seq !== s)
    begin
      n_errors++;
      $display("ERROR t=%0t timeout waiting for state %0d", $time, s);
      stop_test();
    end
  endtask

  task automatic pulse_trip();
    prot.main_trip = 1'b1;
    cyc(1);
    prot.main_trip = 1'b0;
    cyc(2);
  endtask

  task automatic clear_all();
    cmd.clear_key = 1'b1;
    cyc(1);
    cmd.clear_key = 1'b0;
    cyc(1);
  endtask

  task automatic close_cb();
    man_close = 1'b1;
    cyc(10);
    man_close = 1'b0;
    cyc(5);
  endtask

  // Start rising edge, then open the breaker while dead time runs
  task automatic shot(input logic [2:0] n);
    prot.main_start = 1'b1;
    cyc(1);
    chk(seq, RC_DEAD, "dead state");
    chk(shots, n, "shot count");
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    wait_seq(RC_CLOSING, 200);
  endtask

  initial
  begin
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    cfg = '0;
    prot = '0;
    cmd = '0;
    pin_rst = 1'b0;
    pin_blk = 1'b0;
    cb_trip = 1'b0;
    man_close = 1'b0;
    cb_fault = 8'h00;
    three_live = 1'b1;
    one_live = 1'b0;
    sync_ok = 1'b0;
    cfg.dead_ms = 16'h0003;
    cfg.reclaim_ms = 16'h0005;
    cfg.shots_max = 3'h2;
    cfg.sequence_coordination_enable = 1'b1;
    cfg.blk_inst_main = 5'h01;
    cfg.blk_inst_sef = 5'h02;
    repeat (5) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    cyc(1);
    chk(lockout, 0, "reset lockout");
    chk(seq, RC_IDLE, "reset state");
    cyc(2);
    chk(bus_live, 1, "bus live");
    chk(line_live, 0, "line live");
    chk(bim, 1, "trip one main blocked");
    chk(bis, 0, "trip one earth free");
    cfg.primary_voltage_input_side = 1'b1;
    cyc(2);
    chk(line_live, 1, "line live swapped");
    one_live = 1'b1;
    cyc(3);
    chk(permit, 0, "permit out of limits");
    sync_ok = 1'b1;
    cyc(3);
    chk(permit, 1, "permit in limits");
    sync_ok = 1'b0;
    for (int p = 0; p < 6; p++)
    begin
      cfg.phase_sel = rc_phase_t'(p);
      cyc(2);
      chk(sref, 8'(p), "check phase");
    end
    $display("test voltages done");
    for (int b = 0; b < 8; b++)
    begin
      cb_fault = 8'h01 << b;
      cyc(2);
      chk(lockout, 1, "fault lockout");
      chk(cause, 5'h04, "fault cause");
      cb_fault = 8'h00;
      cmd.cb_lockout_reset = 1'b1;
      cyc(1);
      cmd.cb_lockout_reset = 1'b0;
      cyc(1);
      chk(lockout, 0, "command reset");
    end
    // Pin reset held while the cause is live must be refused
    cb_fault = 8'h01;
    cyc(2);
    pin_rst = 1'b1;
    cyc(8);
    chk(lockout, 1, "pin reset refused");
    cb_fault = 8'h00;
    cyc(8);
    chk(lockout, 0, "pin reset");
    chk(cause, 5'h00, "alarms cleared");
    pin_rst = 1'b0;
    cyc(6);
    $display("test faults done");
    cfg.mode = RC_NON_AUTO;
    cfg.inactive_trip_response = 1'b1;
    pulse_trip();
    chk(lockout, 1, "inactive trip");
    chk(cause, 5'h01, "inactive cause");
    chk(shown, 1, "flags shown");
    cmd.led_reset = 1'b1;
    cyc(1);
    cmd.led_reset = 1'b0;
    chk(rec_clr, 1, "record clear");
    cyc(1);
    chk(led, 0, "led reset");
    cmd.led_reset = 1'b1;
    cyc(1);
    cmd.led_reset = 1'b0;
    chk(rec_clr, 0, "reset refused unshown");
    cmd.flag_view = 1'b1;
    cyc(1);
    cmd.flag_view = 1'b0;
    chk(shown, 1, "flags selected");
    cmd.clear_key = 1'b1;
    cyc(1);
    cmd.clear_key = 1'b0;
    chk(flg_clr, 1, "flags clear");
    chk(lockout, 0, "clear key");
    cfg.mode = RC_LIVE_LINE;
    pulse_trip();
    chk(lockout, 1, "live line trip");
    clear_all();
    cfg.inactive_trip_response = 1'b0;
    cfg.mode = RC_AUTO;
    cb_fault = 8'h01;
    cyc(2);
    cb_fault = 8'h00;
    cfg.mode = RC_NON_AUTO;
    cyc(3);
    chk(lockout, 1, "non auto kept");
    cfg.mode = RC_AUTO;
    cyc(1);
    cfg.lockout_reset_source_non_auto = 1'b1;
    cfg.mode = RC_NON_AUTO;
    cyc(3);
    chk(lockout, 0, "non auto clears");
    cfg.mode = RC_AUTO;
    cfg.lockout_reset_source_non_auto = 1'b0;
    cyc(2);
    // Fault inside the manual close window, then reset by a manual close
    cfg.man_close_inhibit = 1'b1;
    cfg.man_close_flt_lockout = 1'b1;
    cfg.lockout_reset_source_close = 1'b1;
    cfg.inhibit_ms = 16'h0004;
    cfg.mc_rst_ms = 16'h0003;
    close_cb();
    pulse_trip();
    chk(lockout, 1, "man close fault");
    chk(cause, 5'h02, "man close cause");
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    cyc(6);
    close_cb();
    chk(lockout, 1, "close delay running");
    cyc(20);
    chk(lockout, 0, "close delay reset");
    cfg.man_close_inhibit = 1'b0;
    cfg.man_close_flt_lockout = 1'b0;
    cfg.lockout_reset_source_close = 1'b0;
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    cyc(6);
    $display("test reset paths done");
    // Shot one closes with the sides out of limits
    close_cb();
    shot(3'h1);
    chk(reclose, 1, "first shot unchecked");
    chk(bim, 0, "trip two main free");
    chk(bis, 1, "trip two earth blocked");
    cyc(30);
    chk(seq, RC_CLOSING, "reclaim held by start");
    prot.main_start = 1'b0;
    wait_seq(RC_RECLAIM, 20);
    shot(3'h2);
    cyc(8);
    chk(reclose, 0, "second shot checked");
    sync_ok = 1'b1;
    cyc(3);
    chk(reclose, 1, "second shot permitted");
    prot.main_start = 1'b0;
    wait_seq(RC_RECLAIM, 40);
    pulse_trip();
    chk(lockout, 1, "final shot lockout");
    chk(cause, 5'h08, "final shot cause");
    clear_all();
    wait_seq(RC_IDLE, 200);
    shot(3'h1);
    pin_blk = 1'b1;
    cyc(6);
    chk(lockout, 1, "block lockout");
    chk(cause, 5'h10, "block cause");
    chk(reclose, 0, "no reclose locked");
    pin_blk = 1'b0;
    prot.main_start = 1'b0;
    cyc(6);
    clear_all();
    wait_seq(RC_IDLE, 200);
    cfg.sequence_coordination_enable = 1'b0;
    prot.main_start = 1'b1;
    cyc(3);
    chk(seq, RC_IDLE, "start ignored");
    prot.main_start = 1'b0;
    // Uncoordinated: trip with breaker closed, then the breaker opens
    close_cb();
    pulse_trip();
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    wait_seq(RC_DEAD, 20);
    chk(shots, 1, "breaker trip counts");
    wait_seq(RC_IDLE, 200);
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    cyc(6);
    $display("test sequence done");
    cfg.system_function_link_bit = 1'b1;
    pulse_trip();
    close_cb();
    cyc(11900);
    chk(led, 1, "led before three s");
    cyc(200);
    chk(led, 0, "led auto reset");
    cb_trip = 1'b1;
    cyc(1);
    cb_trip = 1'b0;
    pulse_trip();
    close_cb();
    prot.any_start = 1'b1;
    cyc(1);
    prot.any_start = 1'b0;
    cyc(12200);
    chk(led, 1, "auto reset cancelled");
    $display("test trip led done");
    stop_test();
  end
endmodule
